// ### core/reset_and_misc_control.sv
`timescale 1ns/1ps
// Operation
// - Upper five bits of misc_control always read as ones.
// - After any reset misc_control reads FAh: guard bit low, sense bit high.
// - Bit two is read-only and mirrors the frame sync level.
// - Sense bit 0 selects falling edge wake; 1 adds low-level wake.
// - Sense bit takes only the first register write after reset.
// - Writing one to the guard bit clears the watchdog counter.
// - Programmable option: guard bit low at reset; setting it enables watchdog.
// - Writing zero never disables a running watchdog; only reset does.
// - CPU clock is the oscillator clock divided by two.
// - On reset exit fetch the vector at 3FFEh high and 3FFFh low.
// - Power-up holds reset for 4096 CPU cycles after oscillator starts.
// - After the delay reset holds while the reset pin stays low.
// - During power-up reset the device drives the reset pin low.
// - Watchdog timeout pulls the reset pin low, seen as external reset.
// - Resets clear timer prescaler and load timer counter with FFFCh.
// - Resets clear data direction registers and timer interrupt enables.
// - Resets set the stack pointer to 00FFh.
// - Resets set interrupt mask; wait and stop entry clear it.
// - Oscillator held off 4096 cycles on power-up and stop wake; stop_wake is not read, the stop hold starts at stop entry.
// - Resets clear EEPROM control, PWM/BRM, DAC and sync registers.
// - Enabled watchdog counter advances every 1024 CPU cycles.
// - Watchdog counter reaching 8 issues a system reset.
module reset_and_misc_control #(
	parameter int STABILISE = rst_misc_pkg::STABILISE_CYCLES, // Start-up delay in CPU cycles.
	parameter int PRESCALE = rst_misc_pkg::GUARD_PRESCALE, // Watchdog prescale in CPU cycles.
	parameter bit AUTO_ENABLE = 1'b0 // Watchdog enabled after start-up.
) (
	input wire logic aclk, // Oscillator-rate clock.
	input wire logic aresetn, // Power-on reset, active low.
	input wire logic [31:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [31:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read valid.
	input wire logic s_axi_rready, // Read ready.
	input wire logic osc_enable, // Oscillator running.
	input wire logic reset_pin_in, // Reset pin level.
	output logic reset_pin_out, // Reset pin driven value, always low.
	output logic reset_pin_oe_n, // Low while the device pulls the pin.
	input wire logic frame_sync_state, // Vsync level from the sync processor.
	input wire logic [7:0] wake_pins, // Port B wake inputs.
	input wire logic [7:0] wake_src_en, // Port B wake source selects.
	output logic wake_request, // Wake interrupt trigger: falling-edge pulse, or held while low when sense is set.
	input wire logic stop_enter, // Stop instruction executed.
	input wire logic wait_enter, // Wait instruction executed.
	input wire logic stop_wake, // Wake event out of stop; not read, stop ends after the start-up delay.
	output logic cpu_clk_en, // One pulse per CPU clock.
	output logic cpu_hold, // CPU held in reset or stabilisation.
	output logic periph_clear, // Peripheral reset pulse level.
	output logic osc_hold, // Oscillator disabled.
	output logic vector_fetch, // Pulse: fetch reset vector.
	output logic [15:0] vector_hi_addr, // Vector high byte address.
	output logic [15:0] vector_lo_addr, // Vector low byte address.
	output logic [15:0] timer_count_init, // Timer counter reset load.
	output logic [15:0] stack_init, // Stack pointer reset load.
	output logic int_mask, // Interrupt mask flag of condition_flags.
	output logic guard_running // Watchdog enabled.
);
	typedef enum logic [2:0] {ST_POR, ST_PIN, ST_RUN, ST_PULL, ST_STOP} seq_e;
	seq_e st_r, st_nxt;
	localparam logic [12:0] STAB_LAST = 13'(STABILISE - 1);
	localparam logic [10:0] PRE_LAST = 11'(PRESCALE - 1);
	logic div_r, div_nxt;
	logic pin_m_r, pin_s_r;
	logic [7:0] wake_m_r, wake_s_r;
	logic [12:0] cnt_r, cnt_nxt;
	logic [10:0] pre_r, pre_nxt;
	logic [3:0] gcnt_r, gcnt_nxt;
	logic run_r, run_nxt;
	logic sense_r, sense_nxt, written_r, written_nxt, guard_r, guard_nxt;
	logic mask_r, mask_nxt;
	logic [7:0] wprev_r;
	logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
	logic [31:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic vf_r, vf_nxt;
	logic timeout, do_write, guard_kick;
	logic [7:0] misc_rd;

	always_comb begin
		misc_rd = {rst_misc_pkg::UPPER_ONES, frame_sync_state, sense_r, guard_r};
	end

	// Pin synchroniser: the second stage is the only reader of the first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_m_r <= 1'b0;
			pin_s_r <= 1'b0;
			wake_m_r <= 8'hff;
			wake_s_r <= 8'hff;
			wprev_r <= 8'hff;
		end else begin
			pin_m_r <= reset_pin_in;
			pin_s_r <= pin_m_r;
			wake_m_r <= wake_pins;
			wake_s_r <= wake_m_r;
			wprev_r <= wake_s_r;
		end
	end

	// Falling edge, or low level when sense is set.
	always_comb begin
		wake_request = |(wake_src_en & ((wprev_r & ~wake_s_r) | (sense_r ? ~wake_s_r : 8'h00)));
	end

	assign timeout = run_r && (gcnt_r == rst_misc_pkg::GUARD_MAX);
	assign do_write = aw_r && w_r && !bv_r;
	assign guard_kick = do_write && (awaddr_r == rst_misc_pkg::MISC_CONTROL_ADDR)
		&& wstrb_r[0] && wdata_r[rst_misc_pkg::GUARD_BIT];

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		div_nxt = ~div_r;
		vf_nxt = 1'b0;
		case (st_r)
			ST_POR, ST_STOP: begin
				if (!osc_enable) begin
					cnt_nxt = '0;
				end else if (div_r) begin
					if (cnt_r == STAB_LAST) begin
						cnt_nxt = '0;
						st_nxt = (st_r == ST_STOP) ? ST_RUN : ST_PIN;
						vf_nxt = (st_r == ST_STOP) ? 1'b0 : pin_s_r;
					end else begin
						cnt_nxt = cnt_r + 13'h1;
					end
				end
			end
			ST_PIN: begin
				if (pin_s_r) begin
					st_nxt = ST_RUN;
					vf_nxt = 1'b1;
				end
			end
			ST_PULL: begin
				// Hold the pin low two CPU cycles, then treat it as an external reset.
				if (div_r) begin
					cnt_nxt = cnt_r + 13'h1;
				end
				if (div_r && cnt_r == 13'h1) begin
					cnt_nxt = '0;
					st_nxt = ST_PIN;
				end
			end
			default: begin
				if (!pin_s_r) begin
					st_nxt = ST_PIN;
				end else if (timeout || (stop_enter && run_r)) begin
					st_nxt = ST_PULL;
					cnt_nxt = '0;
				end else if (stop_enter) begin
					st_nxt = ST_STOP;
					cnt_nxt = '0;
				end
			end
		endcase
		if (st_r == ST_PIN && !pin_s_r) begin
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_POR;
			cnt_r <= '0;
			div_r <= 1'b0;
			vf_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			div_r <= div_nxt;
			vf_r <= vf_nxt;
		end
	end

	assign periph_clear = (st_r == ST_POR) || (st_r == ST_PIN) || (st_r == ST_PULL);

	// Watchdog, prescaler and mask flag.
	always_comb begin
		pre_nxt = pre_r;
		gcnt_nxt = gcnt_r;
		run_nxt = run_r;
		mask_nxt = mask_r;
		if (periph_clear) begin
			pre_nxt = '0;
			gcnt_nxt = '0;
			run_nxt = 1'b0;
			mask_nxt = 1'b1;
		end else begin
			if (AUTO_ENABLE || (guard_kick && !guard_r) || guard_r) begin
				run_nxt = 1'b1;
			end
			if (stop_enter || wait_enter) begin
				mask_nxt = 1'b0;
			end
			if (run_r && div_r) begin
				pre_nxt = (pre_r == PRE_LAST) ? 11'h0 : pre_r + 11'h1;
				if (pre_r == PRE_LAST && gcnt_r != rst_misc_pkg::GUARD_MAX) begin
					gcnt_nxt = gcnt_r + 4'h1;
				end
			end
			if (guard_kick) begin
				gcnt_nxt = '0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_r <= '0;
			gcnt_r <= '0;
			run_r <= 1'b0;
			mask_r <= 1'b1;
		end else begin
			pre_r <= pre_nxt;
			gcnt_r <= gcnt_nxt;
			run_r <= run_nxt;
			mask_r <= mask_nxt;
		end
	end

	// AXI4-Lite slave and misc_control register.
	always_comb begin
		aw_nxt = aw_r;
		w_nxt = w_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bv_nxt = bv_r;
		bresp_nxt = bresp_r;
		rv_nxt = rv_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		sense_nxt = sense_r;
		written_nxt = written_r;
		guard_nxt = guard_r;
		if (s_axi_awvalid && !aw_r) begin
			aw_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_r) begin
			w_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (do_write) begin
			bv_nxt = 1'b1;
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			if (awaddr_r == rst_misc_pkg::MISC_CONTROL_ADDR) begin
				bresp_nxt = rst_misc_pkg::RESP_OKAY;
				if (wstrb_r[0]) begin
					if (!written_r) begin
						sense_nxt = wdata_r[rst_misc_pkg::SENSE_BIT];
					end
					written_nxt = 1'b1;
					guard_nxt = wdata_r[rst_misc_pkg::GUARD_BIT] | guard_r;
				end
			end else if (awaddr_r == rst_misc_pkg::STATUS_ADDR) begin
				bresp_nxt = rst_misc_pkg::RESP_OKAY;
			end else begin
				bresp_nxt = rst_misc_pkg::RESP_SLVERR;
			end
		end
		if (bv_r && s_axi_bready) begin
			bv_nxt = 1'b0;
		end
		if (s_axi_arvalid && !rv_r) begin
			rv_nxt = 1'b1;
			if (s_axi_araddr == rst_misc_pkg::MISC_CONTROL_ADDR) begin
				rdata_nxt = {24'h0, misc_rd};
				rresp_nxt = rst_misc_pkg::RESP_OKAY;
			end else if (s_axi_araddr == rst_misc_pkg::STATUS_ADDR) begin
				rdata_nxt = {22'h0, st_r, gcnt_r, mask_r, run_r, cpu_hold};
				rresp_nxt = rst_misc_pkg::RESP_OKAY;
			end else begin
				rdata_nxt = '0;
				rresp_nxt = rst_misc_pkg::RESP_SLVERR;
			end
		end else if (rv_r && s_axi_rready) begin
			rv_nxt = 1'b0;
		end
		if (periph_clear) begin
			sense_nxt = rst_misc_pkg::MISC_RESET_VAL[rst_misc_pkg::SENSE_BIT];
			written_nxt = 1'b0;
			guard_nxt = AUTO_ENABLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			bv_r <= 1'b0;
			bresp_r <= '0;
			rv_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= '0;
			sense_r <= rst_misc_pkg::MISC_RESET_VAL[rst_misc_pkg::SENSE_BIT];
			written_r <= 1'b0;
			guard_r <= 1'b0;
		end else begin
			aw_r <= aw_nxt;
			w_r <= w_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bv_r <= bv_nxt;
			bresp_r <= bresp_nxt;
			rv_r <= rv_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			sense_r <= sense_nxt;
			written_r <= written_nxt;
			guard_r <= guard_nxt;
		end
	end

	assign s_axi_awready = !aw_r;
	assign s_axi_wready = !w_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rv_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe_n = !((st_r == ST_POR) || (st_r == ST_PULL));
	assign cpu_clk_en = div_r;
	assign cpu_hold = (st_r != ST_RUN);
	assign osc_hold = (st_r == ST_POR) || (st_r == ST_STOP);
	assign vector_fetch = vf_r;
	assign vector_hi_addr = rst_misc_pkg::RESET_VECTOR_HI;
	assign vector_lo_addr = rst_misc_pkg::RESET_VECTOR_LO;
	assign timer_count_init = rst_misc_pkg::TIMER_COUNT_INIT;
	assign stack_init = rst_misc_pkg::STACK_INIT;
	assign int_mask = mask_r;
	assign guard_running = run_r;

	chk_upper_ones: assert property (@(posedge aclk) disable iff (!aresetn)
		rv_r && !$past(rv_r) && $past(s_axi_araddr) == rst_misc_pkg::MISC_CONTROL_ADDR
		|-> rdata_r[7:3] == 5'h1f) else $error("upper bits not ones");
	chk_reset_value: assert property (@(posedge aclk) disable iff (!aresetn)
		periph_clear |=> sense_r == rst_misc_pkg::MISC_RESET_VAL[rst_misc_pkg::SENSE_BIT]
		&& !written_r) else $error("misc not cleared");
	chk_sense_once: assert property (@(posedge aclk) disable iff (!aresetn)
		written_r && !periph_clear |=> $stable(sense_r)) else $error("sense rewritten");
	chk_kick_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		guard_kick && !periph_clear |=> gcnt_r == 4'h0) else $error("kick ignored");
	chk_guard_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		run_r && !periph_clear |=> run_r) else $error("watchdog stopped");
	chk_div_two: assert property (@(posedge aclk) disable iff (!aresetn)
		div_r |=> !div_r) else $error("clock divide wrong");
	chk_pin_drive: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r == ST_POR |-> !reset_pin_oe_n) else $error("pin not driven");
	chk_timeout_pull: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r == ST_RUN && timeout && pin_s_r |=> st_r == ST_PULL) else $error("no pull");
	chk_pin_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r == ST_PIN && !pin_s_r |=> st_r == ST_PIN) else $error("left reset");
	cov_por_done: cover property (@(posedge aclk) disable iff (!aresetn) vf_r);
	cov_pull: cover property (@(posedge aclk) disable iff (!aresetn) st_r == ST_PULL);
	cov_stop: cover property (@(posedge aclk) disable iff (!aresetn) st_r == ST_STOP);
endmodule // reset_and_misc_control

// ### core/rst_misc_pkg.sv
package rst_misc_pkg;
	localparam logic [31:0] MISC_CONTROL_ADDR = 32'h0000_0044;
	localparam logic [31:0] STATUS_ADDR = 32'h0000_0048;
	localparam logic [7:0] MISC_RESET_VAL = 8'hfa;
	localparam logic [4:0] UPPER_ONES = 5'h1f;
	localparam int SYNC_BIT = 2;
	localparam int SENSE_BIT = 1;
	localparam int GUARD_BIT = 0;
	localparam int STABILISE_CYCLES = 4096;
	localparam int GUARD_PRESCALE = 1024;
	localparam logic [3:0] GUARD_MAX = 4'h8;
	localparam logic [15:0] RESET_VECTOR_HI = 16'h3ffe;
	localparam logic [15:0] RESET_VECTOR_LO = 16'h3fff;
	localparam logic [15:0] TIMER_COUNT_INIT = 16'hfffc;
	localparam logic [15:0] STACK_INIT = 16'h00ff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### tb/reset_source_model.sv
`timescale 1ns/1ps
module reset_source_model (
	input wire logic aclk, // Clock that times a pull.
	input wire logic reset_pin_out, // Device drive value.
	input wire logic reset_pin_oe_n, // Low while the device pulls.
	output logic pin_level // Resolved pin level.
);
	logic ext_low = 1'b0;
	// The pin has a pull-up, so it reads high unless some party pulls it.
	assign pin_level = (reset_pin_oe_n || reset_pin_out) && !ext_low;
	task automatic pull(input int n);
		ext_low <= 1'b1;
		repeat ((n < 3) ? 3 : n) @(posedge aclk);
		ext_low <= 1'b0;
	endtask
endmodule // reset_source_model

// ### tb/reset_and_misc_control_test.sv
`timescale 1ns/1ps
module reset_and_misc_control_test;
	localparam int ST = 8;
	localparam int PS = 4;
	localparam logic [31:0] M = rst_misc_pkg::MISC_CONTROL_ADDR;
	logic aclk = 1'b0, aresetn = 1'b0, osc_enable = 1'b0, frame_sync_state = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_enter = 1'b0, wait_enter = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [7:0] wake_pins = 8'hff, wake_src_en = 8'h01;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic reset_pin_out, reset_pin_oe_n, wake_request, cpu_clk_en, cpu_hold, periph_clear;
	logic osc_hold, vector_fetch, int_mask, guard_running;
	logic [15:0] vector_hi_addr, vector_lo_addr, timer_count_init, stack_init;
	int miscompares = 0, checks_done = 0, seed = 32'h4f3c3d87, n;
	logic [33:0] qr[$];
	logic [1:0] qb[$];
	always #5 aclk = ~aclk;
	reset_and_misc_control #(.STABILISE(ST), .PRESCALE(PS), .AUTO_ENABLE(1'b0))
		reset_and_misc_control_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.osc_enable, .reset_pin_in(pin), .reset_pin_out, .reset_pin_oe_n, .frame_sync_state,
		.wake_pins, .wake_src_en, .wake_request, .stop_enter, .wait_enter, .stop_wake(1'b0),
		.cpu_clk_en, .cpu_hold, .periph_clear, .osc_hold, .vector_fetch, .vector_hi_addr,
		.vector_lo_addr, .timer_count_init, .stack_init, .int_mask, .guard_running);
	reset_source_model reset_source_model_inst (.aclk, .reset_pin_out, .reset_pin_oe_n,
		.pin_level(pin));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Handshakes are judged at the falling edge, where all channels are settled.
	always @(negedge aclk) begin
		if (s_axi_bvalid && s_axi_bready && qb.size() > 0) begin
			chk(s_axi_bresp, qb.pop_front(), "bresp");
		end
		if (s_axi_rvalid && s_axi_rready && qr.size() > 0) begin
			chk({s_axi_rresp, s_axi_rdata}, qr.pop_front(), "read");
		end
	end
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ta, tw, tb;
		int k;
		k = 0;
		qb.push_back(e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bready && s_axi_bvalid;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
			k++;
			if (k > 50) begin
				miscompares++;
				break;
			end
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask
	task automatic rd(input logic [31:0] a, input logic [33:0] e);
		logic ta, tr;
		int k;
		k = 0;
		qr.push_back(e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rready && s_axi_rvalid;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
			k++;
			if (k > 50) begin
				miscompares++;
				break;
			end
		end while (s_axi_arvalid || s_axi_rready);
	endtask
	// Reads the control register with a random frame sync level held during the read.
	task automatic rdm(input logic [1:0] lo);
		logic f;
		int r;
		r = $random(seed);
		f = r[0];
		@(posedge aclk);
		frame_sync_state <= f;
		rd(M, {26'h0, rst_misc_pkg::UPPER_ONES, f, lo});
	endtask
	task automatic boot(input int lo, input logic im, input logic v);
		int k;
		logic seen, p;
		k = 0;
		seen = 1'b0;
		chk(cpu_hold, 1'b1, "hold");
		while (cpu_hold !== 1'b0 && k < 3000) begin
			@(negedge aclk);
			k++;
			seen |= vector_fetch;
		end
		@(negedge aclk);
		seen |= vector_fetch;
		chk(seen, v, "vector fetch");
		chk(k >= lo && k < 3000, 1'b1, "start delay");
		chk({vector_hi_addr, vector_lo_addr, timer_count_init, stack_init},
			64'h3ffe_3fff_fffc_00ff, "reset loads");
		chk({int_mask, guard_running}, {im, 1'b0}, "flags");
		p = cpu_clk_en;
		@(negedge aclk);
		chk(cpu_clk_en, !p, "clk");
	endtask
	task automatic wk(input logic lvl);
		int c;
		c = 0;
		wake_pins <= 8'hff;
		repeat (3) @(posedge aclk);
		wake_pins <= 8'hfd;
		repeat (3) @(negedge aclk) c += wake_request;
		chk(c, 0, "disabled wake");
		@(posedge aclk);
		wake_pins <= 8'hfc;
		repeat (3) @(negedge aclk) c += wake_request;
		chk(c > 0, 1'b1, "edge wake");
		@(negedge aclk);
		chk(wake_request, lvl, "level wake");
		wake_pins <= 8'hff;
	endtask
	task automatic watch_clk();
		logic p;
		@(negedge aclk);
		p = cpu_clk_en;
		repeat (4) begin
			@(negedge aclk);
			chk(cpu_clk_en, !p, "cpu clock");
			p = cpu_clk_en;
		end
	endtask
	task automatic pulse_stop();
		stop_enter <= 1'b1;
		@(posedge aclk);
		stop_enter <= 1'b0;
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (10) @(negedge aclk);
		chk({reset_pin_oe_n, osc_hold, pin}, 3'b010, "power-up pull");
		@(posedge aclk);
		osc_enable <= 1'b1;
		boot(2 * ST, 1'b1, 1'b1);
		watch_clk();
		rdm(2'b10);
		wr(M, $random(seed) & 32'hffff_fff8, rst_misc_pkg::RESP_OKAY);
		rdm(2'b00);
		wk(1'b0);
		wr(32'h0000_0050, 32'h0, rst_misc_pkg::RESP_SLVERR);
		rd(32'h0000_0050, {rst_misc_pkg::RESP_SLVERR, 32'h0});
		wait_enter <= 1'b1;
		@(posedge aclk);
		wait_enter <= 1'b0;
		repeat (2) @(negedge aclk);
		chk(int_mask, 1'b0, "wait mask");
		wr(M, 32'h0000_0003, rst_misc_pkg::RESP_OKAY);
		chk(guard_running, 1'b1, "guard on");
		wr(M, 32'h0000_0000, rst_misc_pkg::RESP_OKAY);
		chk(guard_running, 1'b1, "guard kept");
		rdm(2'b01);
		repeat (8) begin
			repeat (30) @(posedge aclk);
			wr(M, 32'h0000_0001, rst_misc_pkg::RESP_OKAY);
		end
		chk(reset_pin_oe_n, 1'b1, "kick");
		n = 0;
		while (reset_pin_oe_n !== 1'b0 && n < 300) begin
			@(negedge aclk);
			n++;
		end
		chk(n >= 2 * PS * 7 - 4 && n <= 2 * PS * 8 + 8, 1'b1, "timeout");
		chk(pin, 1'b0, "pull pin");
		boot(0, 1'b1, 1'b1);
		rdm(2'b10);
		wr(M, 32'h0000_0002, rst_misc_pkg::RESP_OKAY);
		wr(M, 32'h0000_0000, rst_misc_pkg::RESP_OKAY);
		rdm(2'b10);
		wk(1'b1);
		fork
			reset_source_model_inst.pull(20);
		join_none
		repeat (12) @(negedge aclk);
		chk({cpu_hold, periph_clear}, 2'b11, "pin reset");
		boot(0, 1'b1, 1'b1);
		@(posedge aclk);
		reset_source_model_inst.pull(3);
		repeat (2) @(negedge aclk);
		boot(0, 1'b1, 1'b1);
		pulse_stop();
		repeat (2) @(negedge aclk);
		chk({osc_hold, int_mask}, 2'b10, "stop");
		// The two falling-edge waits above already used two aclk cycles, one CPU cycle, of the stabilisation.
		boot(2 * ST - 2, 1'b0, 1'b0);
		wr(M, 32'h0000_0001, rst_misc_pkg::RESP_OKAY);
		pulse_stop();
		repeat (2) @(negedge aclk);
		chk(reset_pin_oe_n, 1'b0, "stop pull");
		boot(0, 1'b1, 1'b1);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(negedge aclk);
		boot(2 * ST, 1'b1, 1'b1);
		rdm(2'b10);
		give_verdict();
	end
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
endmodule // reset_and_misc_control_test
